// ==== rtl/fsds_pkg.sv ====
// Constants and types for the flash security register and discovery space block
package fsds_pkg;
  localparam int unsigned SEC_BYTES = 256;
  localparam int unsigned SEC_CNT = 4;
  localparam int unsigned SEL_LSB = 12;
  localparam int unsigned SEL_W = 2;
  localparam logic [7:0] OP_RD_SFDP = 8'h5a;
  localparam logic [7:0] OP_RD_SEC = 8'h48;
  localparam logic [7:0] OP_PROG = 8'h42;
  localparam logic [7:0] OP_ERASE = 8'h44;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [7:0] FILL = 8'hff;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] ERASE_LAST = 8'hff;
  // Discovery space map
  localparam logic [7:0] HDR_END = 8'h17;
  localparam logic [7:0] HDR_RSV = 8'h20;
  localparam logic [7:0] PARAM_START = 8'h30;
  localparam logic [7:0] SPACE_END = 8'h7b;
  localparam logic [7:0] MAKER_OFS = 8'h10;
  // Address bits that must be zero for a hit, and the read address step
  localparam logic [23:0] SFDP_MASK = 24'hffff00;
  localparam logic [23:0] SEC_MASK = 24'hffcf00;
  localparam logic [23:0] ADDR_STEP = 24'h000001;
  // Header bytes 00h..17h; entry 10h is replaced by the maker code
  localparam logic [7:0] HDR_ROM [24] = '{
    8'h53, 8'h46, 8'h44, 8'h50,
    8'h08, 8'h01, 8'h01, 8'hff,
    8'h00, 8'h07, 8'h01, 8'h10,
    8'h30, 8'h00, 8'h00, 8'hff,
    8'h00, 8'h00, 8'h01, 8'h03,
    8'h70, 8'h00, 8'h00, 8'hff};
  // Register port
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_LOCK = 8'h04;
  localparam logic [3:0] LOCK_RST = 4'h1;
  localparam logic [31:0] RD_NONE = 32'h0000_0000;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
  } fsds_cmd_t;
  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0] last_op;
    logic [1:0] pad;
    logic busy;
    logic wel;
    logic [3:0] lock;
  } fsds_status_t;
  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_DUMMY, ST_READ, ST_PROG, ST_ERARM, ST_IGN
  } fsds_state_t;
endpackage

// ==== rtl/fsds_sec_space.sv ====
// Serial security registers with read-only discovery space behind an SPI slave
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
// Operation
// - Four separate 256-byte security areas, apart from the main array.
// - A set one-time lock bit write-protects its security area forever; here reset reloads LOCK_RST, clearing the locks of areas 1 to 3.
// - Area 0 holds discovery data; discovery read returns the same content.
// - Areas 1 to 3 erase, program and lock independently of each other.
// - Opcode 5Ah reads discovery space, a space apart from main array.
// - Discovery space is factory-made and read-only; modify attempts are refused.
// - The header starts at byte 0000h, the discovery read entry point.
// - Reserved from 0020h, table at 0030h, end 007Bh, 007Ch-00FFh reserved.
// - Bytes 00h-03h return signature 53h 46h 44h 50h.
// - Byte 04h returns minor revision 08h.
// - Byte 05h returns major revision 01h.
// - Byte 06h returns header count 01h, meaning two headers.
// - Byte 07h returns access protocol FFh.
// - Byte 08h returns table identifier low byte 00h.
// - Byte 09h returns table minor revision 07h.
// - Byte 0Ah returns table major revision 01h.
// - Byte 0Bh returns table length 10h, sixteen double words.
// - Bytes 0Ch-0Eh point to table at 30h, upper bytes 00h.
// - Byte 0Fh returns FFh, legacy table identifier high byte.
// - Bytes 10h-12h: maker code, minor 00h, major 01h.
// - Length 03h at 13h, pointer 70h at 14h-16h, 17h reads FFh.
module fsds_sec_space #(
  parameter logic [7:0] MAKER_ID_P = 8'ha5, // Arbitrary neutral value
  parameter logic [7:0] PARAM_BYTE_P = 8'hff
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_di_i,
  output logic spi_do_o,
  output logic spi_do_oe_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);

  logic sclk_m_q, sclk_s_q, sclk_p_q;
  logic cs_m_q, cs_s_q, cs_p_q;
  logic di_m_q, di_s_q;
  logic sclk_rise, sclk_fall, sel, cs_end, byte_done;
  logic [7:0] rx_byte;
  fsds_pkg::fsds_state_t state_q;
  fsds_pkg::fsds_cmd_t cmd_q;
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic [1:0] abyte_q;
  logic [7:0] byte_q;
  logic do_q, oe_q;
  logic ld_fire;
  logic [23:0] ld_addr;
  logic [1:0] ld_sel, ld_midx, p_sel, p_midx;
  logic [7:0] ld_data;
  logic p_ok, prog_we, erase_go, wren_go;
  logic [7:0] sec_mem_q [1:3][fsds_pkg::SEC_BYTES];
  logic [3:0] lock_q;
  logic wel_q;
  logic erase_busy_q;
  logic [1:0] erase_reg_q;
  logic [7:0] erase_idx_q;
  logic [31:0] rdata_q;
  fsds_pkg::fsds_status_t status;

  function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
    if (a == fsds_pkg::MAKER_OFS)
      sfdp_byte = MAKER_ID_P;
    else if (a <= fsds_pkg::HDR_END)
      sfdp_byte = fsds_pkg::HDR_ROM[a[4:0]];
    else if (a >= fsds_pkg::PARAM_START && a <= fsds_pkg::SPACE_END)
      sfdp_byte = PARAM_BYTE_P;
    else
      sfdp_byte = fsds_pkg::FILL;
  endfunction
  // Header table also

  function automatic logic sec_hit(input logic [23:0] a);
    sec_hit = (a & fsds_pkg::SEC_MASK) == '0;
  endfunction

  // Two-stage synchronisers for the link pins
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_p_q <= 1'b1;
      di_m_q <= 1'b0;
      di_s_q <= 1'b0;
    end
    else
    begin
      sclk_m_q <= spi_sclk_i;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      cs_m_q <= spi_cs_n_i;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      di_m_q <= spi_di_i;
      di_s_q <= di_m_q;
    end
  end

  assign sclk_rise = sclk_s_q & ~sclk_p_q;
  assign sclk_fall = ~sclk_s_q & sclk_p_q;
  assign sel = ~cs_s_q;
  assign cs_end = cs_s_q & ~cs_p_q;
  assign rx_byte = {shift_q[6:0], di_s_q};
  assign byte_done = sel && sclk_rise && (bit_cnt_q == fsds_pkg::BIT_LAST);

  // Command sequencer: opcode, address, dummy byte, data phase
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= fsds_pkg::ST_OPC;
      cmd_q <= '0;
      shift_q <= '0;
      bit_cnt_q <= '0;
      abyte_q <= '0;
    end
    else if (!sel)
    begin
      state_q <= fsds_pkg::ST_OPC;
      bit_cnt_q <= '0;
      abyte_q <= '0;
    end
    else if (sclk_rise)
    begin
      shift_q <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done)
      begin
        case (state_q)
          fsds_pkg::ST_OPC:
          begin
            cmd_q.opcode <= rx_byte;
            case (rx_byte)
              fsds_pkg::OP_RD_SFDP,
              fsds_pkg::OP_RD_SEC,
              fsds_pkg::OP_PROG,
              fsds_pkg::OP_ERASE: state_q <= fsds_pkg::ST_ADDR;
              default: state_q <= fsds_pkg::ST_IGN;
            endcase
          end
          fsds_pkg::ST_ADDR:
          begin
            cmd_q.addr <= {cmd_q.addr[15:0], rx_byte};
            abyte_q <= abyte_q + 2'h1;
            if (abyte_q == fsds_pkg::ADDR_LAST)
            begin
              if (cmd_q.opcode == fsds_pkg::OP_PROG)
                state_q <= fsds_pkg::ST_PROG;
              else if (cmd_q.opcode == fsds_pkg::OP_ERASE)
                state_q <= fsds_pkg::ST_ERARM;
              else
                state_q <= fsds_pkg::ST_DUMMY;
            end
          end
          fsds_pkg::ST_DUMMY: state_q <= fsds_pkg::ST_READ;
          fsds_pkg::ST_READ: cmd_q.addr <= cmd_q.addr + fsds_pkg::ADDR_STEP;
          // Programming wraps within the 256-byte area
          fsds_pkg::ST_PROG: cmd_q.addr[7:0] <= cmd_q.addr[7:0] + 8'h01;
          fsds_pkg::ST_ERARM: state_q <= fsds_pkg::ST_IGN;
          fsds_pkg::ST_IGN: state_q <= fsds_pkg::ST_IGN;
          default: state_q <= fsds_pkg::ST_IGN;
        endcase
      end
    end
  end

  // Next outgoing byte: from the discovery table or from areas 1 to 3
  assign ld_fire = byte_done && (state_q == fsds_pkg::ST_DUMMY || state_q == fsds_pkg::ST_READ);
  assign ld_addr = (state_q == fsds_pkg::ST_DUMMY) ? cmd_q.addr
                   : cmd_q.addr + fsds_pkg::ADDR_STEP;
  assign ld_sel = ld_addr[fsds_pkg::SEL_LSB +: fsds_pkg::SEL_W];
  assign ld_midx = (ld_sel == 2'h0) ? 2'h1 : ld_sel;

  always_comb
  begin
    ld_data = fsds_pkg::FILL;
    if (cmd_q.opcode == fsds_pkg::OP_RD_SFDP)
    begin
      // Separate space: the main array is never consulted
      if ((ld_addr & fsds_pkg::SFDP_MASK) == '0)
        ld_data = sfdp_byte(ld_addr[7:0]);
    end
    else if (sec_hit(ld_addr))
    begin
      if (ld_sel == 2'h0)
        ld_data = sfdp_byte(ld_addr[7:0]);
      else
        ld_data = sec_mem_q[ld_midx][ld_addr[7:0]];
    end
  end

  // Output shifter: new bit after each falling edge, msb first
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      byte_q <= '0;
      do_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      if (ld_fire)
        byte_q <= ld_data;
      if (!sel)
        do_q <= 1'b0;
      else if (sclk_fall && state_q == fsds_pkg::ST_READ)
        do_q <= byte_q[fsds_pkg::BIT_LAST - bit_cnt_q];
      oe_q <= sel && (state_q == fsds_pkg::ST_READ);
    end
  end

  assign spi_do_o = do_q;
  assign spi_do_oe_o = oe_q;

  // Modify permission: area 0 is never writable, locked areas never again
  assign p_sel = cmd_q.addr[fsds_pkg::SEL_LSB +: fsds_pkg::SEL_W];
  assign p_midx = (p_sel == 2'h0) ? 2'h1 : p_sel;
  assign p_ok = sec_hit(cmd_q.addr) && (p_sel != 2'h0)
                && !lock_q[p_sel] && wel_q && !erase_busy_q;
  assign prog_we = byte_done && (state_q == fsds_pkg::ST_PROG) && p_ok;
  assign erase_go = cs_end && (state_q == fsds_pkg::ST_ERARM) && p_ok;
  assign wren_go = cs_end && (state_q == fsds_pkg::ST_IGN)
                   && (cmd_q.opcode == fsds_pkg::OP_WREN) && (bit_cnt_q == '0);

  // Array has no reset: content is nonvolatile
  always_ff @(posedge sys_clk_i)
  begin
    if (erase_busy_q)
      sec_mem_q[erase_reg_q][erase_idx_q] <= fsds_pkg::ERASED;
    else if (prog_we)
      sec_mem_q[p_midx][cmd_q.addr[7:0]] <= sec_mem_q[p_midx][cmd_q.addr[7:0]] & rx_byte;
  end

  // Erase walks one byte per cycle through the chosen area only
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      erase_busy_q <= 1'b0;
      erase_reg_q <= 2'h1;
      erase_idx_q <= '0;
    end
    else if (erase_go)
    begin
      erase_busy_q <= 1'b1;
      erase_reg_q <= p_midx;
      erase_idx_q <= '0;
    end
    else if (erase_busy_q)
    begin
      erase_idx_q <= erase_idx_q + 8'h01;
      if (erase_idx_q == fsds_pkg::ERASE_LAST)
        erase_busy_q <= 1'b0;
    end
  end

  // Write enable latch: one modify command per enable
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      wel_q <= 1'b0;
    else if (wren_go)
      wel_q <= 1'b1;
    else if (erase_go || (cs_end && state_q == fsds_pkg::ST_PROG))
      wel_q <= 1'b0;
  end

  // Lock bits only ever set; area 0 starts locked. Reset models power-up load.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      lock_q <= fsds_pkg::LOCK_RST;
    else if (reg_wr_i && reg_addr_i == fsds_pkg::REG_LOCK)
      lock_q <= lock_q | reg_wdata_i[3:0];
  end

  always_comb
  begin
    status = '0;
    status.lock = lock_q;
    status.wel = wel_q;
    status.busy = erase_busy_q;
    status.last_op = cmd_q.opcode;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_q <= fsds_pkg::RD_NONE;
    else if (reg_rd_i && reg_addr_i == fsds_pkg::REG_STATUS)
      rdata_q <= status;
    else if (reg_rd_i && reg_addr_i == fsds_pkg::REG_LOCK)
      rdata_q <= {28'h0000000, lock_q};
    else
      rdata_q <= fsds_pkg::RD_NONE;
  end

  assign reg_rdata_o = rdata_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_sfdp_ld(logic [23:0] a);
    ld_fire && (cmd_q.opcode == fsds_pkg::OP_RD_SFDP) && (ld_addr == a);
  endsequence

  sequence s_read_byte_end;
    byte_done && (state_q == fsds_pkg::ST_READ);
  endsequence

  AST_SIG: assert property (s_sfdp_ld(24'h000000) |=> byte_q == 8'h53)
    else $error("signature byte 0 wrong");
  AST_SIG3: assert property (s_sfdp_ld(24'h000003) |=> byte_q == 8'h50)
    else $error("signature byte 3 wrong");
  AST_MINOR: assert property (s_sfdp_ld(24'h000004) |=> byte_q == 8'h08)
    else $error("minor revision wrong");
  AST_NPH: assert property (s_sfdp_ld(24'h000006) |=> byte_q == 8'h01)
    else $error("header count wrong");
  AST_PTR: assert property (s_sfdp_ld(24'h00000c) |=> byte_q == 8'h30)
    else $error("table pointer wrong");
  AST_PTR1: assert property (s_sfdp_ld(24'h000014) |=> byte_q == 8'h70)
    else $error("second table pointer wrong");
  AST_FILL: assert property (ld_fire && cmd_q.opcode == fsds_pkg::OP_RD_SFDP
    && ld_addr[7:0] >= 8'h7c |=> byte_q == 8'hff)
    else $error("reserved byte not filler");
  AST_RO: assert property ((prog_we || erase_go) |-> p_sel != 2'h0)
    else $error("area 0 modified");
  AST_LOCK: assert property ((prog_we || erase_go) |-> !lock_q[p_sel])
    else $error("locked area modified");
  AST_INC: assert property (s_read_byte_end |=> cmd_q.addr == $past(cmd_q.addr) + 24'h1)
    else $error("read address did not advance");
  AST_CSREL: assert property (cs_end |=> state_q == fsds_pkg::ST_OPC ##1 !spi_do_oe_o)
    else $error("deselect did not end read");
  AST_ERASE: assert property (erase_go |=> erase_busy_q ##255 erase_busy_q ##1 !erase_busy_q)
    else $error("erase length wrong");

endmodule // fsds_sec_space

// ==== dv/fsds_host_model.sv ====
// Host SPI controller model issuing single-bit mode 0 frames
`timescale 1ns/10ps
module fsds_host_model (
  output logic spi_sclk_o,
  output logic spi_cs_n_o,
  output logic spi_di_o,
  input wire logic spi_do_i,
  input wire logic spi_do_oe_i
);
  localparam realtime HALF = 62.5;
  logic [7:0] rx_q[$];
  logic oe_ok;
  logic oe_seen;
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_di_o = 1'b0;
    oe_ok = 1'b0;
    oe_seen = 1'b0;
  end
  // Data set while the clock is low, device output taken at the rise
  task automatic bit_cycle(input logic d, output logic q);
    spi_di_o = d;
    #(HALF) spi_sclk_o = 1'b1;
    q = spi_do_i;
    oe_seen = spi_do_oe_i;
    #(HALF) spi_sclk_o = 1'b0;
  endtask
  // Opcode, optional address, dummy clocks, then nb bytes sent from wd and read back
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit use_a,
                       input int dummy, input int nb, input logic [7:0] wd);
    logic [31:0] hdr;
    logic [7:0] b;
    logic q;
    hdr = {op, a};
    rx_q.delete();
    oe_ok = 1'b1;
    spi_cs_n_o = 1'b0;
    for (int i = 31; i >= (use_a ? 0 : 24); i--)
      bit_cycle(hdr[i], q);
    repeat (dummy) bit_cycle(~spi_di_o, q);
    repeat (nb)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bit_cycle(wd[i], q);
        b[i] = q;
        oe_ok = oe_ok & oe_seen;
      end
      rx_q.push_back(b);
    end
    #(HALF) spi_cs_n_o = 1'b1;
    // Line released: keep it moving so a stale level never looks valid
    spi_di_o = ~spi_di_o;
    #100;
  endtask
endmodule // fsds_host_model

// ==== dv/fsds_sec_space_tb.sv ====
// Self-checking bench for the security register and discovery space block
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module fsds_sec_space_tb;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] PARAM = 8'h5c;
  localparam logic [31:0] ROWS [32] = '{
    32'h00000053, 32'h00000146, 32'h00000244, 32'h00000350,
    32'h00000408, 32'h00000501, 32'h00000601, 32'h000007ff,
    32'h00000800, 32'h00000907, 32'h00000a01, 32'h00000b10,
    32'h00000c30, 32'h00000d00, 32'h00000e00, 32'h00000fff,
    {24'h000010, MAKER}, 32'h00001100, 32'h00001201, 32'h00001303,
    32'h00001470, 32'h00001500, 32'h00001600, 32'h000017ff,
    32'h000020ff, 32'h00002fff, {24'h000030, PARAM}, {24'h00007b, PARAM},
    32'h00007cff, 32'h0000ffff, 32'h000100ff, 32'h001000ff};
  logic sys_clk_i;
  logic reset_i;
  logic spi_sclk, spi_cs_n, spi_di, spi_do, spi_do_oe;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr, reg_rd;
  logic [31:0] reg_rdata;
  int errors;
  int num_checks;
  fsds_sec_space #(.MAKER_ID_P(MAKER), .PARAM_BYTE_P(PARAM)) i_fsds_sec_space (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .spi_sclk_i(spi_sclk), .spi_cs_n_i(spi_cs_n),
    .spi_di_i(spi_di), .spi_do_o(spi_do), .spi_do_oe_o(spi_do_oe), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  fsds_host_model i_fsds_host_model (
    .spi_sclk_o(spi_sclk), .spi_cs_n_o(spi_cs_n), .spi_di_o(spi_di), .spi_do_i(spi_do),
    .spi_do_oe_i(spi_do_oe));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One register access; read data stand in the cycle after the strobe
  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= ~wr;
    @(posedge sys_clk_i);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic rd1(input logic [7:0] op, input logic [23:0] a, input logic [7:0] exp);
    i_fsds_host_model.frame(op, a, 1'b1, 8, 1, 8'h00);
    `CHK(i_fsds_host_model.rx_q[0], exp)
    `CHK(i_fsds_host_model.oe_ok, 1'b1)
    `CHK(spi_do_oe, 1'b0)
  endtask
  // Write enable first, since program and erase are dropped without it
  task automatic wr_cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    i_fsds_host_model.frame(fsds_pkg::OP_WREN, 24'h000000, 1'b0, 0, 0, 8'h00);
    i_fsds_host_model.frame(op, a, 1'b1, 0, (op == fsds_pkg::OP_PROG) ? 1 : 0, d);
  endtask
  initial
  begin
    // Full run is about 35k system clocks; allow a wide margin
    #600000;
    errors++;
    print_verdict();
  end
  initial
  begin
    logic [31:0] q;
    errors = 0;
    num_checks = 0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reset_i = 1'b1;
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    reg_acc(1'b0, fsds_pkg::REG_STATUS, 32'h00000000, q);
    `CHK(q, 32'h00000001)
    `CHK(spi_do_oe, 1'b0)
    @(posedge sys_clk_i);
    #1 `CHK(reg_rdata, 32'h00000000)
    reg_acc(1'b0, 8'h08, 32'h00000000, q);
    `CHK(q, 32'h00000000)
    $display("test reset done");
    foreach (ROWS[k])
      rd1(fsds_pkg::OP_RD_SFDP, ROWS[k][31:8], ROWS[k][7:0]);
    $display("test header table done");
    i_fsds_host_model.frame(fsds_pkg::OP_RD_SFDP, 24'h000000, 1'b1, 8, 6, 8'h00);
    for (int k = 0; k < 6; k++)
      `CHK(i_fsds_host_model.rx_q[k], ROWS[k][7:0])
    rd1(fsds_pkg::OP_RD_SEC, 24'h000010, MAKER);
    rd1(fsds_pkg::OP_RD_SEC, 24'h000000, 8'h53);
    $display("test streaming done");
    for (int n = 1; n < 4; n++)
    begin
      wr_cmd(fsds_pkg::OP_ERASE, {10'h000, 2'(n), 12'h000}, 8'h00);
      reg_acc(1'b0, fsds_pkg::REG_STATUS, 32'h00000000, q);
      `CHK(q[5], 1'b1)
      `CHK(q[15:8], fsds_pkg::OP_ERASE)
      repeat (300) @(posedge sys_clk_i);
      reg_acc(1'b0, fsds_pkg::REG_STATUS, 32'h00000000, q);
      `CHK(q[5:4], 2'b00)
    end
    wr_cmd(fsds_pkg::OP_PROG, 24'h001005, 8'h96);
    for (int n = 1; n < 4; n++)
      rd1(fsds_pkg::OP_RD_SEC, {10'h000, 2'(n), 12'h005}, (n == 1) ? 8'h96 : 8'hff);
    $display("test erase and program done");
    wr_cmd(fsds_pkg::OP_PROG, 24'h000000, 8'h00);
    wr_cmd(fsds_pkg::OP_ERASE, 24'h000000, 8'h00);
    repeat (300) @(posedge sys_clk_i);
    rd1(fsds_pkg::OP_RD_SFDP, 24'h000000, 8'h53);
    rd1(fsds_pkg::OP_RD_SEC, 24'h000001, 8'h46);
    $display("test read only space done");
    reg_acc(1'b1, fsds_pkg::REG_LOCK, 32'h00000002, q);
    reg_acc(1'b1, fsds_pkg::REG_LOCK, 32'h00000000, q);
    reg_acc(1'b0, fsds_pkg::REG_LOCK, 32'h00000000, q);
    `CHK(q[3:0], 4'h3)
    wr_cmd(fsds_pkg::OP_PROG, 24'h001006, 8'h00);
    wr_cmd(fsds_pkg::OP_ERASE, 24'h001000, 8'h00);
    repeat (300) @(posedge sys_clk_i);
    wr_cmd(fsds_pkg::OP_PROG, 24'h002006, 8'h3c);
    rd1(fsds_pkg::OP_RD_SEC, 24'h001005, 8'h96);
    rd1(fsds_pkg::OP_RD_SEC, 24'h001006, 8'hff);
    rd1(fsds_pkg::OP_RD_SEC, 24'h002006, 8'h3c);
    $display("test lock done");
    print_verdict();
  end
endmodule // fsds_sec_space_tb
